/* File: logic/sfpe_pkg.sv */
// package: opcodes, geometry, timing and states of the program/erase sequencer
package sfpe_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OPC_PAGE_PROG   = 8'h02;
  localparam logic [7:0] OPC_QUAD_PROG   = 8'h32;
  localparam logic [7:0] OPC_SECT_ERASE  = 8'h20;
  localparam logic [7:0] OPC_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLK64_ERASE = 8'hD8;

  // ****************************************
  // geometry
  // ****************************************
  localparam int          ADDR_BYTES  = 3;
  localparam logic [23:0] PAGE_BYTES  = 24'h000100;
  localparam logic [23:0] SECT_BYTES  = 24'h001000;
  localparam logic [23:0] BLK32_BYTES = 24'h008000;
  localparam logic [23:0] BLK64_BYTES = 24'h010000;
  localparam logic [23:0] FLASH_BYTES = 24'h200000;
  localparam logic [2:0]  SEC_CAP_BP  = 3'h5;

  // erase size codes on the array port
  localparam logic [1:0] ERASE_4K  = 2'h0;
  localparam logic [1:0] ERASE_32K = 2'h1;
  localparam logic [1:0] ERASE_64K = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS             = 5;
  localparam int PROG_TIME_US              = 700;
  localparam int SECT_ERASE_TIME_US        = 30000;
  localparam int SMALL_BLOCK_ERASE_TIME_US = 120000;
  localparam int BLOCK_ERASE_TIME_US       = 150000;
  localparam int PROG_CYCLES       = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SECT_ERASE_CYCLES = SECT_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BLK32_CYCLES      = SMALL_BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BLK64_CYCLES      = BLOCK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_OPC  = 3'h1,
    ST_ADDR = 3'h2,
    ST_DATA = 3'h3,
    ST_SKIP = 3'h4,
    ST_BUSY = 3'h5
  } sfpe_state_e;

endpackage

/* File: logic/sfpe_sync.sv */
// two-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module sfpe_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_out <= sync_next;
    end
  end

endmodule

/* File: logic/sfpe_link_rx.sv */
// link-clock shifter: assembles bytes from one or four data lines
`timescale 1ns/1ps
module sfpe_link_rx
  import sfpe_pkg::*;
(
  // link
  input  wire logic       link_clk,
  input  wire logic       line_cs_n,
  input  wire logic [3:0] line_in,
  input  wire logic       resetn,
  // to system domain
  output logic      [7:0] byte_data,
  output logic            byte_toggle,
  output logic            mid_byte
);

  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [7:0] opc_reg;
  logic [7:0] opc_next;
  logic [7:0] data_next;
  logic       tog_next;
  logic       mid_next;
  logic       quad;
  logic [3:0] sum;

  always_comb
  begin
    quad = (opc_reg == OPC_QUAD_PROG) && (cnt_reg > 3'(ADDR_BYTES));
    shift_next = quad ? {shift_reg[3:0], line_in} : {shift_reg[6:0], line_in[0]};
    sum        = {1'b0, bit_reg} + (quad ? 4'h4 : 4'h1);
    bit_next   = sum[2:0];
    cnt_next   = cnt_reg;
    opc_next   = opc_reg;
    data_next  = byte_data;
    tog_next   = byte_toggle;
    mid_next   = (sum[2:0] != 3'h0);
    if (sum[3])
    begin
      data_next = shift_next;
      tog_next  = ~byte_toggle;
      if (cnt_reg == 3'h0)
        opc_next = shift_next;
      if (cnt_reg != 3'h7)
        cnt_next = cnt_reg + 3'h1;
    end
  end

  // frame state cleared by deselect; clock may stand still outside frames
  always_ff @(posedge link_clk or posedge line_cs_n)
  begin
    if (line_cs_n)
    begin
      shift_reg <= 8'h00;
      bit_reg   <= 3'h0;
      cnt_reg   <= 3'h0;
      opc_reg   <= 8'h00;
    end
    else
    begin
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      cnt_reg   <= cnt_next;
      opc_reg   <= opc_next;
    end
  end

  // handed-over values survive deselect so the far side sees no false event
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      byte_data   <= 8'h00;
      byte_toggle <= 1'b0;
      mid_byte    <= 1'b0;
    end
    else
    begin
      byte_data   <= data_next;
      byte_toggle <= tog_next;
      mid_byte    <= mid_next;
    end
  end

endmodule

/* File: logic/sfpe_flash_seq.sv */
// program/erase command decoder and self-timed sequencer
`timescale 1ns/1ps
module sfpe_flash_seq
  import sfpe_pkg::*;
#(
  parameter int PROG_CNT  = sfpe_pkg::PROG_CYCLES,
  parameter int SECT_CNT  = sfpe_pkg::SECT_ERASE_CYCLES,
  parameter int BLK32_CNT = sfpe_pkg::BLK32_CYCLES,
  parameter int BLK64_CNT = sfpe_pkg::BLK64_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // link
  input  wire logic        link_clk,
  input  wire logic        line_cs_n,
  input  wire logic [3:0]  line_in,
  // configuration
  input  wire logic        quad_enable,
  input  wire logic        protect_bit2,
  input  wire logic        protect_bit1,
  input  wire logic        protect_bit0,
  input  wire logic        top_bottom_select,
  input  wire logic        sector_granularity,
  // latch control
  input  wire logic        set_write_enable,
  input  wire logic        clear_write_enable,
  // status
  output logic             busy,
  output logic             write_enable_latch,
  // array port
  output logic             array_wr_en,
  output logic [23:0]      array_wr_addr,
  output logic [7:0]       array_wr_data,
  output logic             erase_req,
  output logic [23:0]      erase_addr,
  output logic [1:0]       erase_size
);
  import sfpe_pkg::*;

  // ****************************************
  // protection decode
  // ****************************************
  function automatic logic is_protected(input logic [23:0] lo, input logic [23:0] hi,
                                        input logic [2:0] bp, input logic tb, input logic sec);
    logic [23:0] span;
    logic [23:0] rlo;
    logic [23:0] rhi;
    begin
      span = 24'h000000;
      rlo  = 24'h000000;
      rhi  = 24'h000000;
      if (bp == 3'h0)
        is_protected = 1'b0;
      else if (bp == 3'h7)
        is_protected = 1'b1;
      else
      begin
        // fine granularity tops out at 32 KB
        if (sec)
          span = (bp >= SEC_CAP_BP) ? BLK32_BYTES : (SECT_BYTES << (bp - 3'h1));
        else
          span = BLK64_BYTES << (bp - 3'h1);
        rlo = tb ? 24'h000000 : (FLASH_BYTES - span);
        rhi = rlo + span - 24'h000001;
        is_protected = (hi >= rlo) && (lo <= rhi);
      end
    end
  endfunction

  // ****************************************
  // link side and crossing
  // ****************************************
  logic [7:0] lk_data;
  logic       lk_tog;
  logic       lk_mid;
  logic [2:0] sync_s;

  sfpe_link_rx u_link_rx (
    .link_clk    (link_clk),
    .line_cs_n   (line_cs_n),
    .line_in     (line_in),
    .resetn      (resetn),
    .byte_data   (lk_data),
    .byte_toggle (lk_tog),
    .mid_byte    (lk_mid)
  );

  // byte data is stable for a whole byte time after its toggle
  sfpe_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({line_cs_n, lk_tog, lk_mid}),
    .sync_out (sync_s)
  );

  // ****************************************
  // state
  // ****************************************
  sfpe_state_e state_reg;
  sfpe_state_e state_next;
  logic        cs_seen_reg;
  logic        cs_seen_next;
  logic        tog_seen_reg;
  logic        tog_seen_next;
  logic        rise_d_reg;
  logic        rise_d_next;
  logic [7:0]  opc_reg;
  logic [7:0]  opc_next;
  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic [1:0]  acnt_reg;
  logic [1:0]  acnt_next;
  logic [7:0]  idx_reg;
  logic [7:0]  idx_next;
  logic        got_reg;
  logic        got_next;
  logic [7:0]  buf_reg [256];
  logic [7:0]  buf_next [256];
  logic [255:0] vld_reg;
  logic [255:0] vld_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  logic        walk_reg;
  logic        walk_next;
  logic        busy_next;
  logic        wel_next;
  logic        wr_en_next;
  logic [23:0] wr_addr_next;
  logic [7:0]  wr_data_next;
  logic        er_req_next;
  logic [23:0] er_addr_next;
  logic [1:0]  er_size_next;

  logic        cs_s;
  logic        byte_ev;
  logic        cs_rise;
  logic        is_prog;
  logic        opc_ok;
  logic        frame_ok;
  logic [23:0] er_span;
  logic [23:0] lo;
  logic [31:0] er_cnt;

  always_comb
  begin
    cs_s          = sync_s[2];
    byte_ev       = sync_s[1] ^ tog_seen_reg;
    cs_rise       = cs_s & ~cs_seen_reg;
    cs_seen_next  = cs_s;
    tog_seen_next = sync_s[1];
    rise_d_next   = cs_rise;
    state_next    = state_reg;
    opc_next      = opc_reg;
    addr_next     = addr_reg;
    acnt_next     = acnt_reg;
    idx_next      = idx_reg;
    got_next      = got_reg;
    buf_next      = buf_reg;
    vld_next      = vld_reg;
    timer_next    = timer_reg;
    walk_next     = walk_reg;
    busy_next     = busy;
    wel_next      = write_enable_latch;
    wr_en_next    = 1'b0;
    wr_addr_next  = array_wr_addr;
    wr_data_next  = array_wr_data;
    er_req_next   = 1'b0;
    er_addr_next  = erase_addr;
    er_size_next  = erase_size;
    is_prog       = (opc_reg == OPC_PAGE_PROG) || (opc_reg == OPC_QUAD_PROG);
    opc_ok = write_enable_latch &&
             ((lk_data == OPC_PAGE_PROG) || ((lk_data == OPC_QUAD_PROG) && quad_enable) ||
              (lk_data == OPC_SECT_ERASE) || (lk_data == OPC_BLK32_ERASE) ||
              (lk_data == OPC_BLK64_ERASE));
    case (opc_reg)
      OPC_SECT_ERASE:  er_span = SECT_BYTES;
      OPC_BLK32_ERASE: er_span = BLK32_BYTES;
      default:         er_span = BLK64_BYTES;
    endcase
    lo = is_prog ? (addr_reg & ~(PAGE_BYTES - 24'h000001)) : (addr_reg & ~(er_span - 24'h000001));
    // commit only on a byte boundary with the right byte count
    frame_ok = !sync_s[0] && (state_reg == ST_DATA) && (is_prog ? got_reg : !got_reg);
    case (opc_reg)
      OPC_SECT_ERASE:  er_cnt = 32'(SECT_CNT);
      OPC_BLK32_ERASE: er_cnt = 32'(BLK32_CNT);
      default:         er_cnt = 32'(BLK64_CNT);
    endcase

    // latch set or cleared only between cycles
    if (state_reg != ST_BUSY)
    begin
      if (clear_write_enable)
        wel_next = 1'b0;
      if (set_write_enable)
        wel_next = 1'b1;
    end

    case (state_reg)
      ST_IDLE:
      begin
        if (!cs_s)
          state_next = ST_OPC;
      end
      ST_OPC:
      begin
        if (byte_ev)
        begin
          opc_next  = lk_data;
          acnt_next = 2'h0;
          got_next  = 1'b0;
          vld_next  = '0;
          state_next = opc_ok ? ST_ADDR : ST_SKIP;
        end
        else if (rise_d_reg)
          state_next = ST_IDLE;
      end
      ST_ADDR:
      begin
        if (byte_ev)
        begin
          addr_next = {addr_reg[15:0], lk_data};
          acnt_next = acnt_reg + 2'h1;
          if (acnt_reg == 2'(ADDR_BYTES - 1))
          begin
            state_next = ST_DATA;
            idx_next   = lk_data;
          end
        end
        else if (rise_d_reg)
          state_next = ST_IDLE;
      end
      ST_DATA:
      begin
        if (byte_ev)
        begin
          got_next = 1'b1;
          buf_next[idx_reg] = lk_data;
          vld_next[idx_reg] = 1'b1;
          idx_next          = idx_reg + 8'h01;
        end
        else if (rise_d_reg)
        begin
          if (frame_ok && !is_protected(lo, lo + (is_prog ? PAGE_BYTES : er_span) - 24'h000001,
                                        {protect_bit2, protect_bit1, protect_bit0},
                                        top_bottom_select, sector_granularity))
          begin
            state_next = ST_BUSY;
            busy_next  = 1'b1;
            timer_next = is_prog ? 32'(PROG_CNT) : er_cnt;
            walk_next  = is_prog;
            idx_next   = 8'h00;
            er_req_next  = !is_prog;
            er_addr_next = lo;
            er_size_next = (opc_reg == OPC_SECT_ERASE) ? ERASE_4K :
                           (opc_reg == OPC_BLK32_ERASE) ? ERASE_32K : ERASE_64K;
          end
          else
            state_next = ST_IDLE;
        end
      end
      ST_SKIP:
      begin
        if (rise_d_reg)
          state_next = ST_IDLE;
      end
      ST_BUSY:
      begin
        if (walk_reg)
        begin
          wr_en_next   = vld_reg[idx_reg];
          wr_addr_next = {addr_reg[23:8], idx_reg};
          wr_data_next = buf_reg[idx_reg];
          idx_next     = idx_reg + 8'h01;
          if (idx_reg == 8'hFF)
            walk_next = 1'b0;
        end
        // frames during the cycle are ignored
        if (timer_reg <= 32'h1)
        begin
          busy_next = 1'b0;
          wel_next   = 1'b0;
          walk_next  = 1'b0;
          timer_next = 32'h0;
          state_next = cs_s ? ST_IDLE : ST_SKIP;
        end
        else
          timer_next = timer_reg - 32'h1;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_reg          <= ST_IDLE;
      cs_seen_reg        <= 1'b1;
      tog_seen_reg       <= 1'b0;
      rise_d_reg         <= 1'b0;
      opc_reg            <= 8'h00;
      addr_reg           <= 24'h000000;
      acnt_reg           <= 2'h0;
      idx_reg            <= 8'h00;
      got_reg            <= 1'b0;
      vld_reg            <= '0;
      timer_reg          <= 32'h0;
      walk_reg           <= 1'b0;
      busy               <= 1'b0;
      write_enable_latch <= 1'b0;
      array_wr_en        <= 1'b0;
      array_wr_addr      <= 24'h000000;
      array_wr_data      <= 8'h00;
      erase_req          <= 1'b0;
      erase_addr         <= 24'h000000;
      erase_size         <= 2'h0;
    end
    else
    begin
      state_reg          <= state_next;
      cs_seen_reg        <= cs_seen_next;
      tog_seen_reg       <= tog_seen_next;
      rise_d_reg         <= rise_d_next;
      opc_reg            <= opc_next;
      addr_reg           <= addr_next;
      acnt_reg           <= acnt_next;
      idx_reg            <= idx_next;
      got_reg            <= got_next;
      vld_reg            <= vld_next;
      timer_reg          <= timer_next;
      walk_reg           <= walk_next;
      busy               <= busy_next;
      write_enable_latch <= wel_next;
      array_wr_en        <= wr_en_next;
      array_wr_addr      <= wr_addr_next;
      array_wr_data      <= wr_data_next;
      erase_req          <= er_req_next;
      erase_addr         <= er_addr_next;
      erase_size         <= er_size_next;
    end
  end

  // page buffer: contents need no reset, the valid mask guards them
  always_ff @(posedge clk_sys)
  begin
    buf_reg <= buf_next;
  end

endmodule

/* File: verification/sfpe_flash_seq_sva.sv */
// checker: busy timing, latch and array-port relations of the sequencer
`timescale 1ns/1ps
module sfpe_flash_seq_sva
  import sfpe_pkg::*;
#(
  parameter int PROG_CNT  = 300,
  parameter int SECT_CNT  = 20,
  parameter int BLK32_CNT = 30,
  parameter int BLK64_CNT = 40
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // watched signals
  input wire logic        line_cs_n,
  input wire logic        busy,
  input wire logic        write_enable_latch,
  input wire logic        array_wr_en,
  input wire logic [23:0] array_wr_addr,
  input wire logic        erase_req,
  input wire logic [23:0] erase_addr,
  input wire logic [1:0]  erase_size
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ******************************
  // busy length bookkeeping
  // ******************************
  int cnt_reg, cnt_next, len_reg, len_next;
  always_comb
  begin
    cnt_next = busy ? cnt_reg + 1 : 0;
    len_next = len_reg;
    // kind latched on first busy cycle, erase_req marks erase
    if (busy && cnt_reg == 0)
      len_next = !erase_req ? PROG_CNT : erase_size == ERASE_4K ? SECT_CNT :
                 erase_size == ERASE_32K ? BLK32_CNT : BLK64_CNT;
  end
  always_ff @(posedge clk_sys)
  begin
    cnt_reg <= !resetn ? 0 : cnt_next;
    len_reg <= !resetn ? 0 : len_next;
  end
  // ******************************
  // assertions
  // ******************************
  busy_length_a: assert property ($fell(busy) |-> cnt_reg == len_reg)
    else $error("busy length wrong");
  latch_clear_a: assert property ($fell(busy) |-> $fell(write_enable_latch))
    else $error("latch not cleared with busy");
  latch_needed_a: assert property ($rose(busy) |-> write_enable_latch)
    else $error("cycle started without latch");
  latch_frozen_a: assert property (busy && $past(busy) |-> $stable(write_enable_latch))
    else $error("latch moved during cycle");
  erase_start_a: assert property (erase_req |-> $rose(busy))
    else $error("erase request off cycle start");
  erase_align_a: assert property (erase_req |-> (erase_size == ERASE_4K && erase_addr[11:0] == 12'h000) ||
    (erase_size == ERASE_32K && erase_addr[14:0] == 15'h0000) || (erase_size == ERASE_64K && erase_addr[15:0] == 16'h0000))
    else $error("erase base or size wrong");
  write_busy_a: assert property (array_wr_en |-> busy)
    else $error("array write outside cycle");
  write_walk_a: assert property (array_wr_en && $past(array_wr_en) |->
    array_wr_addr == {$past(array_wr_addr[23:8]), $past(array_wr_addr[7:0]) + 8'h01})
    else $error("write walk leaves page");
  commit_deselect_a: assert property ($rose(busy) |-> $past(line_cs_n, 3))
    else $error("cycle began with select low");
endmodule

/* File: verification/sfpe_host_bfm.sv */
// host-side serial driver that frames program and erase commands
`timescale 1ns/1ps
module sfpe_host_bfm (
  // link pins
  output logic       link_clk,
  output logic       line_cs_n,
  output logic [3:0] line_in
);
  initial
  begin
    link_clk  = 1'b0;
    line_cs_n = 1'b1;
    line_in   = 4'h5;
  end
  // data set while clock low, captured on the rise
  task automatic tick(input logic [3:0] v);
    line_in = v;
    #6 link_clk = 1'b1;
    #6 link_clk = 1'b0;
  endtask
  // select low whole frame, msb first
  task automatic frame(input logic [7:0] q[$], input bit quad, input int extra);
    int i;
    int b;
    line_cs_n = 1'b0;
    #10;
    for (i = 0; i < q.size(); i++)
      // quad data on four lines, high nibble first
      if (quad && i > 3)
        for (b = 4; b >= 0; b -= 4) tick(q[i][b+:4]);
      else
        for (b = 7; b >= 0; b--) tick({~line_in[3:1], q[i][b]});
    // stray bits only when a test wants a torn byte
    for (i = 0; i < extra; i++) tick({~line_in[3:1], 1'(i)});
    #10 line_cs_n = 1'b1;
    // released lines show the inverse, never a held value
    line_in = ~line_in;
    #30;
  endtask
endmodule

/* File: verification/sfpe_flash_seq_tb.sv */
// testbench: random and corner program/erase frames against the sequencer
`timescale 1ns/1ps
module sfpe_flash_seq_tb;
  import sfpe_pkg::*;
  // ******************************
  // signals
  // ******************************
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        link_clk, line_cs_n, quad_enable, protect_bit2, protect_bit1, protect_bit0;
  logic        top_bottom_select, sector_granularity, set_write_enable, clear_write_enable;
  logic        busy, write_enable_latch, array_wr_en, erase_req;
  logic [3:0]  line_in;
  logic [23:0] array_wr_addr, erase_addr, er_a;
  logic [7:0]  array_wr_data;
  logic [1:0]  erase_size, er_s;
  logic [7:0]  got [256];
  logic [7:0]  exp [256];
  logic [7:0]  eq [$];
  logic [15:0] page;
  int          error_cnt, n_checks, wr_cnt, er_cnt, bad_pg, cyc, i;
  always #2.5 clk_sys = ~clk_sys;
  sfpe_flash_seq #(.PROG_CNT(300), .SECT_CNT(20), .BLK32_CNT(30), .BLK64_CNT(40)) dut_u (.clk_sys, .resetn,
    .link_clk, .line_cs_n, .line_in, .quad_enable, .protect_bit2, .protect_bit1, .protect_bit0, .top_bottom_select,
    .sector_granularity, .set_write_enable, .clear_write_enable, .busy, .write_enable_latch, .array_wr_en,
    .array_wr_addr, .array_wr_data, .erase_req, .erase_addr, .erase_size);
  sfpe_host_bfm host_u (.link_clk, .line_cs_n, .line_in);
  // ******************************
  // array-port monitor and timeout
  // ******************************
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (array_wr_en === 1'b1)
    begin
      wr_cnt <= wr_cnt + 1;
      got[array_wr_addr[7:0]] <= array_wr_data;
      if (array_wr_addr[23:8] !== page) bad_pg <= bad_pg + 1;
    end
    if (erase_req === 1'b1)
    begin
      er_cnt <= er_cnt + 1;
      er_a <= erase_addr;
      er_s <= erase_size;
    end
    if (cyc == 60000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [25:0] eexp(input logic [7:0] opc, input logic [23:0] a);
    if (opc == OPC_SECT_ERASE) return {ERASE_4K, a & ~(SECT_BYTES - 24'h000001)};
    if (opc == OPC_BLK32_ERASE) return {ERASE_32K, a & ~(BLK32_BYTES - 24'h000001)};
    return {ERASE_64K, a & ~(BLK64_BYTES - 24'h000001)};
  endfunction
  // one frame: latch set or cleared first, then outcome compared
  task automatic cmd(input logic [7:0] opc, input logic [23:0] a, input int n, input int extra, input bit we,
                     input bit ok);
    logic [7:0] q[$];
    logic [7:0] d;
    bit         prog;
    int         j;
    prog = opc == OPC_PAGE_PROG || opc == OPC_QUAD_PROG;
    q = {opc, a[23:16], a[15:8], a[7:0]};
    for (j = 0; j < 256; j++) got[j] = 8'hXX;
    for (j = 0; j < 256; j++) exp[j] = 8'hXX;
    for (j = 0; j < n; j++)
    begin
      d = 8'($urandom);
      q.push_back(d);
      exp[8'(a[7:0] + 8'(j))] = d;
    end
    @(negedge clk_sys);
    set_write_enable = we;
    clear_write_enable = !we;
    @(negedge clk_sys);
    {set_write_enable, clear_write_enable} = 2'h0;
    page = a[23:8];
    wr_cnt = 0;
    er_cnt = 0;
    bad_pg = 0;
    host_u.frame(q, opc == OPC_QUAD_PROG, extra);
    for (j = 0; j < 12 && busy !== 1'b1; j++) @(negedge clk_sys);
    chk("busy", ok, busy);
    for (j = 0; j < 400 && busy === 1'b1; j++) @(negedge clk_sys);
    chk("latch", ok ? 1'b0 : we, write_enable_latch);
    if (prog)
    begin
      chk("writes", ok ? (n > 256 ? 256 : n) : 0, wr_cnt);
      chk("page", 0, bad_pg);
      chk("erase count", 0, er_cnt);
      for (j = 0; j < 256; j++) chk("data", ok ? exp[j] : 8'hXX, got[j]);
    end
    else
    begin
      chk("erase count", ok, er_cnt);
      if (ok) chk("erase", eexp(opc, a), {er_s, er_a});
    end
  endtask
  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    {quad_enable, protect_bit2, protect_bit1, protect_bit0, top_bottom_select} = 5'h00;
    {sector_granularity, set_write_enable, clear_write_enable} = 3'h0;
    {error_cnt, n_checks, wr_cnt, er_cnt, bad_pg, cyc} = '0;
    void'($urandom(32'hA184F804));
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    cmd(OPC_PAGE_PROG, 24'h000010, 4, 0, 0, 0);
    cmd(8'hA5, 24'h000000, 4, 0, 1, 0);
    cmd(OPC_QUAD_PROG, 24'h000000, 4, 0, 1, 0);
    cmd(OPC_PAGE_PROG, 24'h000000, 2, 3, 1, 0);
    cmd(OPC_PAGE_PROG, 24'h000000, 0, 0, 1, 0);
    cmd(OPC_SECT_ERASE, 24'h000000, 1, 0, 1, 0);
    {protect_bit2, protect_bit1, protect_bit0, top_bottom_select} = 4'hE;
    cmd(OPC_PAGE_PROG, 24'($urandom) & 24'h1FFFFF, 4, 0, 1, 0);
    cmd(OPC_BLK64_ERASE, 24'($urandom) & 24'h1FFFFF, 0, 0, 1, 0);
    {protect_bit2, protect_bit1, protect_bit0, quad_enable} = 4'h1;
    // aligned full page onto erased space
    cmd(OPC_PAGE_PROG, 24'h1F0300, 256, 0, 1, 1);
    for (i = 0; i < 4; i++)
      cmd(i[0] ? OPC_QUAD_PROG : OPC_PAGE_PROG, 24'($urandom) & 24'h1FFFFF, 1 + $urandom % 300, 0, 1, 1);
    // protection bits left clear so edge blocks are legal targets
    eq = {OPC_SECT_ERASE, OPC_BLK32_ERASE, OPC_BLK64_ERASE};
    foreach (eq[k]) cmd(eq[k], 24'($urandom) & 24'h1FFFFF, 0, 0, 1, 1);
    eq = {OPC_SECT_ERASE, 8'h10, 8'h00, 8'h00};
    fork
      cmd(OPC_PAGE_PROG, 24'h0400F8, 16, 0, 1, 1);
      begin
        wait (busy === 1'b1);
        host_u.frame(eq, 1'b0, 0);
      end
    join
    // bottom 4 KB guarded with fine granularity
    {protect_bit2, protect_bit1, protect_bit0, top_bottom_select, sector_granularity} = 5'h07;
    cmd(OPC_SECT_ERASE, 24'h000123, 0, 0, 1, 0);
    cmd(OPC_SECT_ERASE, 24'h001000, 0, 0, 1, 1);
    summarize();
  end
endmodule
bind sfpe_flash_seq sfpe_flash_seq_sva #(.PROG_CNT(PROG_CNT), .SECT_CNT(SECT_CNT), .BLK32_CNT(BLK32_CNT),
  .BLK64_CNT(BLK64_CNT)) chk_u (.clk_sys, .resetn, .line_cs_n, .busy, .write_enable_latch, .array_wr_en,
  .array_wr_addr, .erase_req, .erase_addr, .erase_size);
